// *** logic/becr_pkg.sv ***
// Package: offsets, field positions and reset values of the extended config tail
package becr_pkg;
  localparam logic [11:0] OFS_SEC_ERR_CAP   = 12'h138;
  localparam logic [11:0] OFS_HLOG0         = 12'h13c;
  localparam logic [11:0] OFS_HLOG1         = 12'h140;
  localparam logic [11:0] OFS_HLOG2         = 12'h144;
  localparam logic [11:0] OFS_HLOG3         = 12'h148;
  localparam logic [11:0] OFS_VC_HDR        = 12'h150;
  localparam logic [11:0] OFS_PVC_CAP1      = 12'h154;
  localparam logic [11:0] OFS_PVC_CAP2      = 12'h158;
  localparam logic [11:0] OFS_PVC_CTL_STS   = 12'h15c;
  localparam logic [11:0] OFS_VC0_RCAP      = 12'h160;
  localparam logic [11:0] OFS_VC0_RCTL      = 12'h164;
  localparam logic [11:0] OFS_VC0_RSTS      = 12'h168;
  localparam logic [11:0] OFS_XIO           = 12'h304;
  localparam logic [11:0] OFS_TIMERS        = 12'h310;
  // VC capability header fields
  localparam logic [15:0] VC_CAP_ID         = 16'h0002;
  localparam logic [3:0]  VC_CAP_VER        = 4'h1;
  localparam logic [11:0] VC_NEXT_PTR       = 12'h000;
  // VC0 resource control
  localparam logic [6:0]  TCVC_MAP_RST      = 7'h7f;
  localparam int          TCVC_LSB          = 1;
  localparam int          VC_EN_BIT         = 31;
  // Extra io fields
  localparam int          XIO_OCLR_LSB      = 0;
  localparam int          XIO_OSET_LSB      = 4;
  localparam int          XIO_ECLR_LSB      = 8;
  localparam int          XIO_ESET_LSB      = 12;
  localparam int          XIO_IN_LSB        = 16;
  // Timers
  localparam logic [11:0] REPLAY_RST        = 12'h115;
  localparam logic [13:0] ACKLAT_RST        = 14'h00cd;
  localparam int          REPLAY_EN_BIT     = 12;
  localparam int          ACKLAT_LSB        = 16;
  // Header log fields
  localparam int          HL_CMD_LO_LSB     = 36;
  localparam int          HL_CMD_HI_LSB     = 40;
  localparam int          HL_ADDR_LO_LSB    = 64;
  localparam int          HL_ADDR_HI_LSB    = 96;
endpackage : becr_pkg

// *** logic/becr_regs.sv ***
// Register bank: secondary error log, VC capability, extra io, latency timers
// =====================================================================
// Function
// - Write one to clear field zeros output
// - Write one to set field raises output
// - Write one clears output enable bit
// - Write one sets output enable bit
// - Input field shows sampled input pins
// - Log attribute phase into bits 35:0
// - Log first address phase command lower
// - Log DAC second phase command upper
// - Log first phase address third dword
// - Log DAC second address top dword
// - VC next capability pointer reads zero
// - Read-only first error pointer, reset zero
module becr_regs
  import becr_pkg::*;
#(
  parameter int N_IO = 4
) (
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic [11:0]       addr,
  input  wire logic [31:0]       wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [31:0]       rdata,
  input  wire logic              log_valid,
  input  wire logic [4:0]        log_first_err,
  input  wire logic [35:0]       log_attr,
  input  wire logic [3:0]        log_cmd_lo,
  input  wire logic [3:0]        log_cmd_hi,
  input  wire logic [31:0]       log_addr_lo,
  input  wire logic [31:0]       log_addr_hi,
  input  wire logic              log_dac,
  input  wire logic [N_IO-1:0]   extra_general_input,
  output logic      [N_IO-1:0]   extra_general_output,
  output logic      [N_IO-1:0]   extra_general_output_oe_n,
  output logic      [6:0]        tc_vc_map,
  output logic      [11:0]       replay_timer,
  output logic                   replay_timer_en,
  output logic      [13:0]       ack_latency_timer
);

  // =====================================================================
  // Storage
  logic [4:0]      first_err;
  logic [127:0]    hlog;
  logic [N_IO-1:0] out_val;
  logic [N_IO-1:0] out_en;
  logic [N_IO-1:0] in_s1;
  logic [N_IO-1:0] in_s2;

  // =====================================================================
  // Decode
  wire w_xio    = wr && (addr == OFS_XIO);
  wire w_rctl   = wr && (addr == OFS_VC0_RCTL);
  wire w_timers = wr && (addr == OFS_TIMERS);
  wire [N_IO-1:0] oclr = wdata[XIO_OCLR_LSB +: N_IO];
  wire [N_IO-1:0] oset = wdata[XIO_OSET_LSB +: N_IO];
  wire [N_IO-1:0] eclr = wdata[XIO_ECLR_LSB +: N_IO];
  wire [N_IO-1:0] eset = wdata[XIO_ESET_LSB +: N_IO];
  // Set wins when both halves hit the same bit in one write
  logic [N_IO-1:0] next_out_val;
  logic [N_IO-1:0] next_out_en;
  genvar gi;
  generate
    for (gi = 0; gi < N_IO; gi++) begin : g_io_bit
      assign next_out_val[gi] = w_xio ? ((out_val[gi] & ~oclr[gi]) | oset[gi]) : out_val[gi];
      assign next_out_en[gi]  = w_xio ? ((out_en[gi] & ~eclr[gi]) | eset[gi]) : out_en[gi];
    end
  endgenerate

  wire [127:0] next_hlog = {
    log_dac ? log_addr_hi : 32'h0000_0000,
    log_addr_lo,
    20'h0_0000,
    log_dac ? log_cmd_hi : 4'h0,
    log_cmd_lo,
    log_attr
  };

  // Fields are four bits wide; a narrower io count reads zero above it
  wire [3:0]  in_w      = 4'(in_s2);
  wire [3:0]  en_w      = 4'(out_en);
  wire [3:0]  val_w     = 4'(out_val);
  wire [31:0] xio_word  = {12'h000, in_w, en_w, en_w, val_w, val_w};
  wire [31:0] vc_hdr    = {VC_NEXT_PTR, VC_CAP_VER, VC_CAP_ID};
  wire [31:0] rctl_word = {1'b1, 7'h00, 8'h00, 8'h00, tc_vc_map, 1'b1};
  wire [31:0] tmr_word  = {2'b00, ack_latency_timer, 3'b000, replay_timer_en, replay_timer};

  logic [31:0] next_rdata;
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (addr == OFS_SEC_ERR_CAP) begin
      next_rdata = {27'h000_0000, first_err};
    end else if (addr == OFS_HLOG0) begin
      next_rdata = hlog[31:0];
    end else if (addr == OFS_HLOG1) begin
      next_rdata = hlog[63:32];
    end else if (addr == OFS_HLOG2) begin
      next_rdata = hlog[95:64];
    end else if (addr == OFS_HLOG3) begin
      next_rdata = hlog[127:96];
    end else if (addr == OFS_VC_HDR) begin
      next_rdata = vc_hdr;
    end else if (addr == OFS_VC0_RCTL) begin
      next_rdata = rctl_word;
    end else if (addr == OFS_XIO) begin
      next_rdata = xio_word;
    end else if (addr == OFS_TIMERS) begin
      next_rdata = tmr_word;
    end
  end

  // =====================================================================
  // Sequential
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      in_s1 <= '0;
      in_s2 <= '0;
    end else begin
      in_s1 <= extra_general_input;
      in_s2 <= in_s1;  // Two stages, pins are asynchronous
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      out_val                   <= '0;
      out_en                    <= '0;
      extra_general_output      <= '0;
      extra_general_output_oe_n <= '1;
    end else begin
      out_val                   <= next_out_val;
      out_en                    <= next_out_en;
      extra_general_output      <= next_out_val & next_out_en;
      extra_general_output_oe_n <= ~next_out_en;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      first_err <= 5'h00;
      hlog      <= '0;
    end else if (log_valid) begin
      first_err <= log_first_err;
      hlog      <= next_hlog;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tc_vc_map         <= TCVC_MAP_RST;
      replay_timer      <= REPLAY_RST;
      replay_timer_en   <= 1'b0;
      ack_latency_timer <= ACKLAT_RST;
    end else begin
      if (w_rctl) begin
        tc_vc_map <= wdata[TCVC_LSB +: 7];
      end
      if (w_timers) begin
        replay_timer      <= wdata[11:0];
        replay_timer_en   <= wdata[REPLAY_EN_BIT];
        ack_latency_timer <= wdata[ACKLAT_LSB +: 14];
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= 32'h0000_0000;
    end else begin
      rdata <= rd ? next_rdata : 32'h0000_0000;
    end
  end

  // =====================================================================
  // Assertions
  a_clr_zeroes_out: assert property (@(posedge clk) disable iff (!nrst)
    (w_xio && |(oclr & ~oset)) |=> ((out_val & $past(oclr & ~oset)) == '0))
    else $error("clear write left output set");
  a_set_raises_out: assert property (@(posedge clk) disable iff (!nrst)
    w_xio |=> ((out_val & $past(oset)) == $past(oset)))
    else $error("set write did not raise output");
  a_en_clear: assert property (@(posedge clk) disable iff (!nrst)
    (w_xio && |(eclr & ~eset)) |=> ((out_en & $past(eclr & ~eset)) == '0))
    else $error("enable clear failed");
  a_en_set: assert property (@(posedge clk) disable iff (!nrst)
    w_xio |=> ((out_en & $past(eset)) == $past(eset)))
    else $error("enable set failed");
  a_zero_write_keeps: assert property (@(posedge clk) disable iff (!nrst)
    (w_xio && wdata[15:0] == 16'h0000) |=> $stable(out_val) && $stable(out_en))
    else $error("zero write changed io state");
  a_input_read: assert property (@(posedge clk) disable iff (!nrst)
    (rd && addr == OFS_XIO) |=> (rdata[XIO_IN_LSB +: N_IO] == $past(in_s2)))
    else $error("input field mismatch");
  a_log_addr: assert property (@(posedge clk) disable iff (!nrst)
    log_valid |=> (hlog[HL_ADDR_LO_LSB +: 32] == $past(log_addr_lo)) && (hlog[35:0] == $past(log_attr)))
    else $error("header log address or attribute wrong");
  a_log_dac: assert property (@(posedge clk) disable iff (!nrst)
    (log_valid && !log_dac) |=> (hlog[HL_ADDR_HI_LSB +: 32] == 32'h0000_0000) && (hlog[HL_CMD_HI_LSB +: 4] == 4'h0))
    else $error("dac fields set without dac");
  a_cmd_lo: assert property (@(posedge clk) disable iff (!nrst)
    log_valid |=> (hlog[HL_CMD_LO_LSB +: 4] == $past(log_cmd_lo)))
    else $error("command lower wrong");
  a_vc_next: assert property (@(posedge clk) disable iff (!nrst)
    (rd && addr == OFS_VC_HDR) |=> (rdata[31:20] == 12'h000) && (rdata[15:0] == VC_CAP_ID))
    else $error("vc header wrong");
  a_pin_drive: assert property (@(posedge clk) disable iff (!nrst)
    (extra_general_output & extra_general_output_oe_n) == '0)
    else $error("output driven while disabled");

  a_log_attr: assert property (
    @(posedge clk) disable iff (!nrst)
    log_valid |=>
    (hlog[35:0] == $past(log_attr)))
    else $error("attribute phase not logged");

  a_log_cmd_hi: assert property (
    @(posedge clk) disable iff (!nrst)
    (log_valid && log_dac) |=>
    (hlog[HL_CMD_HI_LSB +: 4] == $past(log_cmd_hi)))
    else $error("command upper not logged");

  a_log_addr_hi: assert property (
    @(posedge clk) disable iff (!nrst)
    (log_valid && log_dac) |=>
    (hlog[HL_ADDR_HI_LSB +: 32] == $past(log_addr_hi)))
    else $error("second address not logged");

  a_log_rsvd: assert property (
    @(posedge clk) disable iff (!nrst)
    1'b1 |->
    (hlog[63:44] == 20'h0_0000))
    else $error("reserved log bits set");

  a_log_hold: assert property (
    @(posedge clk) disable iff (!nrst)
    !log_valid |=>
    $stable(hlog))
    else $error("header log changed without capture");

  a_err_capture: assert property (
    @(posedge clk) disable iff (!nrst)
    log_valid |=>
    (first_err == $past(log_first_err)))
    else $error("first error pointer not captured");

  a_err_hold: assert property (
    @(posedge clk) disable iff (!nrst)
    !log_valid |=>
    $stable(first_err))
    else $error("first error pointer changed");

  a_err_read: assert property (
    @(posedge clk) disable iff (!nrst)
    (rd && addr == OFS_SEC_ERR_CAP) |=>
    (rdata == {27'h000_0000, $past(first_err)}))
    else $error("pointer read wrong");

  a_hlog_read_lo: assert property (
    @(posedge clk) disable iff (!nrst)
    (rd && addr == OFS_HLOG0) |=>
    (rdata == $past(hlog[31:0])))
    else $error("log dword zero read wrong");

  a_hlog_read_cmd: assert property (
    @(posedge clk) disable iff (!nrst)
    (rd && addr == OFS_HLOG1) |=>
    (rdata == $past(hlog[63:32])))
    else $error("log dword one read wrong");

  a_hlog_read_addr: assert property (
    @(posedge clk) disable iff (!nrst)
    (rd && addr == OFS_HLOG2) |=>
    (rdata == $past(hlog[95:64])))
    else $error("log dword two read wrong");

  a_hlog_read_top: assert property (
    @(posedge clk) disable iff (!nrst)
    (rd && addr == OFS_HLOG3) |=>
    (rdata == $past(hlog[127:96])))
    else $error("log dword three read wrong");

  a_val_quiet: assert property (
    @(posedge clk) disable iff (!nrst)
    (w_xio && ((oclr | oset) == '0)) |=>
    $stable(out_val))
    else $error("zero output bits changed output");

  a_en_quiet: assert property (
    @(posedge clk) disable iff (!nrst)
    (w_xio && ((eclr | eset) == '0)) |=>
    $stable(out_en))
    else $error("zero enable bits changed enable");

  a_idle_keeps: assert property (
    @(posedge clk) disable iff (!nrst)
    !w_xio |=>
    ($stable(out_val) && $stable(out_en)))
    else $error("io state changed without write");

  a_pin_value: assert property (
    @(posedge clk) disable iff (!nrst)
    1'b1 |->
    (extra_general_output == (out_val & out_en)))
    else $error("output pin differs from stored value");

  a_pin_enable: assert property (
    @(posedge clk) disable iff (!nrst)
    1'b1 |->
    (extra_general_output_oe_n == ~out_en))
    else $error("output enable pin differs from enable");

  a_xio_read_out: assert property (
    @(posedge clk) disable iff (!nrst)
    (rd && addr == OFS_XIO) |=>
    ((rdata[3:0] == $past(val_w)) && (rdata[7:4] == $past(val_w))))
    else $error("output fields read wrong");

  a_xio_read_en: assert property (
    @(posedge clk) disable iff (!nrst)
    (rd && addr == OFS_XIO) |=>
    ((rdata[11:8] == $past(en_w)) && (rdata[15:12] == $past(en_w))))
    else $error("enable fields read wrong");

  a_xio_rsvd: assert property (
    @(posedge clk) disable iff (!nrst)
    (rd && addr == OFS_XIO) |=>
    (rdata[31:20] == 12'h000))
    else $error("reserved io bits read nonzero");

  a_vc_version: assert property (
    @(posedge clk) disable iff (!nrst)
    (rd && addr == OFS_VC_HDR) |=>
    (rdata[19:16] == VC_CAP_VER))
    else $error("vc version wrong");

  a_vc_regs_zero: assert property (
    @(posedge clk) disable iff (!nrst)
    (rd && (addr == OFS_PVC_CAP1 || addr == OFS_PVC_CAP2 || addr == OFS_PVC_CTL_STS ||
            addr == OFS_VC0_RCAP || addr == OFS_VC0_RSTS)) |=>
    (rdata == 32'h0000_0000))
    else $error("vc read-only word nonzero");

  a_rdata_idle: assert property (
    @(posedge clk) disable iff (!nrst)
    !rd |=>
    (rdata == 32'h0000_0000))
    else $error("read data without read");

  a_rctl_read: assert property (
    @(posedge clk) disable iff (!nrst)
    (rd && addr == OFS_VC0_RCTL) |=>
    (rdata == {1'b1, 23'h00_0000, $past(tc_vc_map), 1'b1}))
    else $error("resource control read wrong");

  a_rctl_write: assert property (
    @(posedge clk) disable iff (!nrst)
    w_rctl |=>
    (tc_vc_map == $past(wdata[TCVC_LSB +: 7])))
    else $error("map write lost");

  a_tmr_write: assert property (
    @(posedge clk) disable iff (!nrst)
    w_timers |=>
    ((replay_timer == $past(wdata[11:0])) && (ack_latency_timer == $past(wdata[ACKLAT_LSB +: 14]))))
    else $error("timer write lost");

  a_tmr_read: assert property (
    @(posedge clk) disable iff (!nrst)
    (rd && addr == OFS_TIMERS) |=>
    ((rdata[31:30] == 2'b00) && (rdata[15:13] == 3'b000)))
    else $error("timer reserved bits nonzero");

  c_set_write: cover property (@(posedge clk) disable iff (!nrst) w_xio && |oset);
  c_en_clear:  cover property (@(posedge clk) disable iff (!nrst) w_xio && |eclr);
  c_log_one:   cover property (@(posedge clk) disable iff (!nrst) log_valid && !log_dac);
  c_log_dac:   cover property (@(posedge clk) disable iff (!nrst) log_valid && log_dac);
  c_read_xio:  cover property (@(posedge clk) disable iff (!nrst) rd && addr == OFS_XIO);

endmodule : becr_regs

// *** verif/tb_top.sv ***
// Testbench: register bus sequences against the extended config tail
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import becr_pkg::*;
  // =====================================================================
  // Signals
  logic        clk, nrst, wr, rd, log_valid, log_dac;
  logic [11:0] addr;
  logic [31:0] wdata, rdata, log_addr_lo, log_addr_hi;
  logic [4:0]  log_first_err;
  logic [35:0] log_attr;
  logic [3:0]  log_cmd_lo, log_cmd_hi, egi, ego, ego_oe_n;
  logic [6:0]  tc_vc_map;
  logic [11:0] replay_timer;
  logic        replay_timer_en;
  logic [13:0] ack_latency_timer;
  int          miscompares, samples_checked;
  becr_regs #(.N_IO(4)) dut (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .log_valid(log_valid), .log_first_err(log_first_err), .log_attr(log_attr),
    .log_cmd_lo(log_cmd_lo), .log_cmd_hi(log_cmd_hi), .log_addr_lo(log_addr_lo),
    .log_addr_hi(log_addr_hi), .log_dac(log_dac), .extra_general_input(egi),
    .extra_general_output(ego), .extra_general_output_oe_n(ego_oe_n), .tc_vc_map(tc_vc_map),
    .replay_timer(replay_timer), .replay_timer_en(replay_timer_en),
    .ack_latency_timer(ack_latency_timer));
  // =====================================================================
  // Clock and tasks
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : wr_reg
  // Read data stands only in the cycle after the strobe, so sample there
  task automatic rd_reg(input logic [11:0] a, input logic [31:0] exp);
    @(posedge clk);
    rd <= 1'b1; addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask : rd_reg
  task automatic log_err(input logic [4:0] p, input logic [35:0] at, input logic [3:0] cl,
                         input logic [3:0] ch, input logic [31:0] al, input logic [31:0] ah,
                         input logic dac);
    @(posedge clk);
    log_valid <= 1'b1; log_first_err <= p; log_attr <= at; log_cmd_lo <= cl;
    log_cmd_hi <= ch; log_addr_lo <= al; log_addr_hi <= ah; log_dac <= dac;
    @(posedge clk);
    log_valid <= 1'b0;
  endtask : log_err
  task automatic print_verdict();
    if (miscompares == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict
  // Whole sequence takes well under 200 cycles
  initial begin
    repeat (3000) @(posedge clk);
    miscompares++;
    print_verdict();
  end
  // =====================================================================
  // Tests
  initial begin
    nrst = 1'b0; wr = 1'b0; rd = 1'b0; addr = 12'h000; wdata = 32'h0; egi = 4'h0;
    log_valid = 1'b0; log_first_err = 5'h00; log_attr = 36'h0; log_cmd_lo = 4'h0;
    log_cmd_hi = 4'h0; log_addr_lo = 32'h0; log_addr_hi = 32'h0; log_dac = 1'b0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    rd_reg(OFS_SEC_ERR_CAP, 32'h0);
    rd_reg(OFS_HLOG0, 32'h0);
    rd_reg(OFS_VC0_RCTL, 32'h8000_00ff);
    rd_reg(OFS_TIMERS, 32'h00cd_0115);
    chk({28'h0, ego_oe_n}, 32'h0000_000f);
    // Read-only header must survive a write attempt
    wr_reg(OFS_VC_HDR, 32'hffff_ffff);
    rd_reg(OFS_VC_HDR, 32'h0001_0002);
    rd_reg(12'h14c, 32'h0);
    // Extra io: set, clear, no-op zero writes
    wr_reg(OFS_XIO, 32'h0000_f000);
    chk({28'h0, ego_oe_n}, 32'h0000_0000);
    wr_reg(OFS_XIO, 32'h0000_0050);
    chk({28'h0, ego}, 32'h0000_0005);
    @(posedge clk);
    egi <= 4'ha;
    repeat (4) @(posedge clk);
    rd_reg(OFS_XIO, 32'h000a_ff55);
    wr_reg(OFS_XIO, 32'h0000_0001);
    chk({28'h0, ego}, 32'h0000_0004);
    wr_reg(OFS_XIO, 32'h0000_0600);
    chk({28'h0, ego_oe_n}, 32'h0000_0006);
    chk({28'h0, ego}, 32'h0000_0000);
    wr_reg(OFS_XIO, 32'h0000_0000);
    rd_reg(OFS_XIO, 32'h000a_9944);
    wr_reg(OFS_XIO, 32'h0000_4000);
    chk({28'h0, ego}, 32'h0000_0004);
    // Dual address log, pointer at its top value
    log_err(5'h1f, 36'h9_1234_5678, 4'h6, 4'hd, 32'hcafe_0010, 32'h8000_0001, 1'b1);
    rd_reg(OFS_SEC_ERR_CAP, 32'h0000_001f);
    rd_reg(OFS_HLOG0, 32'h1234_5678);
    rd_reg(OFS_HLOG1, 32'h0000_0d69);
    rd_reg(OFS_HLOG2, 32'hcafe_0010);
    rd_reg(OFS_HLOG3, 32'h8000_0001);
    // Single address log clears the upper phase fields
    log_err(5'h03, 36'h3_0000_0001, 4'h7, 4'hf, 32'h0000_0100, 32'hffff_ffff, 1'b0);
    rd_reg(OFS_HLOG1, 32'h0000_0073);
    rd_reg(OFS_HLOG3, 32'h0000_0000);
    rd_reg(OFS_SEC_ERR_CAP, 32'h0000_0003);
    wr_reg(OFS_SEC_ERR_CAP, 32'hffff_ffff);
    rd_reg(OFS_SEC_ERR_CAP, 32'h0000_0003);
    // Map and timers
    wr_reg(OFS_VC0_RCTL, 32'h0000_00aa);
    rd_reg(OFS_VC0_RCTL, 32'h8000_00ab);
    chk({25'h0, tc_vc_map}, 32'h0000_0055);
    wr_reg(OFS_TIMERS, 32'hffff_ffff);
    rd_reg(OFS_TIMERS, 32'h3fff_1fff);
    chk({19'h0, replay_timer_en, replay_timer}, 32'h0000_1fff);
    chk({18'h0, ack_latency_timer}, 32'h0000_3fff);
    print_verdict();
  end
endmodule : tb_top
